/* pwm_compare_sync_update.sv */
// Purpose: Buffered sync-channel updates, DMA duty mode, compare units, event lines
// Assumes: Zero-wait AHB-Lite slave; channel counters and period ends come from outside
// Notes:   Waveform, dividers, dead-time insertion and fault filtering live elsewhere
`timescale 1ns/1ps

module pwm_compare_sync_update
  import pwm_sync_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire ch0_status_t             ch0_status,
  input  wire logic [NUM_CH-1:0]       chan_period_end,
  input  wire logic                    dma_wr,
  input  wire logic [15:0]             dma_wdata,
  input  wire logic                    dma_tx_end,
  output logic                         dma_req,
  output logic      [NUM_EV-1:0]       event_line,
  output logic                         irq,
  output logic      [NUM_CH-1:0]       chan_enable,
  output chan_cfg_t [NUM_CH-1:0]       chan_cfg
);
  function automatic logic [3:0] wrap_inc(input logic [3:0] cnt, input logic [3:0] max);
    wrap_inc = (cnt == max) ? 4'h0 : cnt + 4'h1;
  endfunction : wrap_inc
  function automatic logic [2:0] lowest_set(input logic [NUM_CH-1:0] m);
    lowest_set = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) lowest_set = 3'(i);
    end
  endfunction : lowest_set
  // Register state
  logic [NUM_CH-1:0]  sync_channel_select;
  logic [1:0]         sync_update_method;
  logic               transfer_request_mode;
  logic [2:0]         transfer_request_compare_select;
  logic               update_unlock;
  logic [3:0]         update_period_reload;
  logic [3:0]         update_period_counter;
  logic [3:0]         upr_staged;
  logic               upr_pend;
  logic [31:0]        isr2;
  logic [31:0]        imr2;
  logic [NUM_CMP-1:0] event_compare_select [NUM_EV];
  chan_cfg_t          staged [NUM_CH];
  logic [NUM_CH-1:0]  prd_pend;
  logic [NUM_CH-1:0]  dty_pend;
  logic [NUM_CH-1:0]  dt_pend;
  logic [NUM_CH-1:0]  dma_todo;
  cmp_cfg_t           cmp_cfg [NUM_CMP];
  cmp_cfg_t           cmp_staged [NUM_CMP];
  logic [NUM_CMP-1:0] cmp_pend;
  logic [3:0]         compare_period_counter [NUM_CMP];
  logic [3:0]         compare_update_counter [NUM_CMP];
  logic [NUM_CMP-1:0] hit_q;
  logic               wr_pend;
  logic [11:0]        wr_addr;
  // Bus decode
  wire        addr_ok   = hsel & htrans[1] & hready;
  wire        rd_acc    = addr_ok & ~hwrite;
  wire [11:0] ra        = haddr[11:0];
  wire [11:0] wa        = wr_addr;
  wire        we        = wr_pend;
  wire        we_cmp    = we & (wa[11:7] == CMP_REGION);
  wire [2:0]  wcmp      = wa[6:4];
  wire        we_ch     = we & (wa[11:8] == CH_REGION);
  wire [2:0]  wch       = wa[7:5];
  wire        rd_isr2   = rd_acc & (ra == OFS_ISR2);
  // Timing events
  wire        sync_end  = chan_period_end[0] & chan_enable[0];
  wire        upr_wrap  = sync_end & (update_period_counter == update_period_reload);
  wire        auto_mode = sync_update_method != UPD_MANUAL;
  wire        dma_mode  = sync_update_method == UPD_DMA;
  wire [2:0]  dma_ch    = lowest_set(dma_todo);
  wire        dma_take  = dma_wr & dma_mode & (|dma_todo);
  // Comparison units
  logic [NUM_CMP-1:0] cmp_hit;
  logic [NUM_CMP-1:0] cmp_upd;
  always_comb begin
    for (int x = 0; x < NUM_CMP; x++) begin
      cmp_hit[x] = cmp_cfg[x].enable & ~ch0_status.fault
                 & (ch0_status.counter == cmp_cfg[x].value)
                 & (~ch0_status.center_align | (cmp_cfg[x].down == ch0_status.count_down))
                 & (compare_period_counter[x] == cmp_cfg[x].trig);
      cmp_upd[x] = sync_end & (compare_update_counter[x] == cmp_cfg[x].uper);
    end
  end
  // Edge of the hit keeps a slow counter from re-firing every clock
  wire [NUM_CMP-1:0] match_pulse = cmp_hit & ~hit_q;
  wire transfer_request_mode_sel = dma_mode & transfer_request_mode;
  wire write_ready_flag_set = auto_mode & (transfer_request_mode_sel ? match_pulse[transfer_request_compare_select]
                                        : upr_wrap);
  wire underrun_flag_set = upr_wrap & dma_mode & (|dma_todo);
  logic [31:0] isr2_set;
  always_comb begin
    isr2_set = 32'h0;
    isr2_set[ISR_WRITE_READY_FLAG]  = write_ready_flag_set;
    isr2_set[ISR_TRANSFER_END_FLAG] = dma_tx_end;
    isr2_set[ISR_UNDERRUN_FLAG]  = underrun_flag_set;
    isr2_set[ISR_COMPARE_MATCH_FLAG +: NUM_CMP] = match_pulse;
    isr2_set[ISR_COMPARE_UPDATE_FLAG +: NUM_CMP] = cmp_upd;
  end
  // Set wins over a read-clear in the same cycle
  wire [31:0] next_isr2 = (isr2 & ~{32{rd_isr2}}) | isr2_set;
  // Per-channel apply strobes
  logic [NUM_CH-1:0] apply_pd;
  logic [NUM_CH-1:0] apply_dty;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (sync_channel_select[c]) begin
        apply_pd[c]  = sync_end & update_unlock;
        apply_dty[c] = sync_end & (auto_mode ? (update_period_counter == update_period_reload)
                                             : update_unlock);
      end else begin
        apply_pd[c]  = chan_period_end[c];
        apply_dty[c] = chan_period_end[c];
      end
    end
  end
  // Read mux, evaluated in the address phase
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    if (ra[1:0] == 2'h0) begin
      case (ra)
        OFS_SR:   rd_word[NUM_CH-1:0] = chan_enable;
        OFS_SCM: begin
          rd_word[NUM_CH-1:0]          = sync_channel_select;
          rd_word[SCM_SYNC_UPDATE_METHOD +: 2]       = sync_update_method;
          rd_word[SCM_TRANSFER_REQUEST_MODE]            = transfer_request_mode;
          rd_word[SCM_TRANSFER_REQUEST_COMPARE_SELECT +: 3]      = transfer_request_compare_select;
        end
        OFS_SCUC: rd_word[0] = update_unlock;
        OFS_SCUP: begin
          rd_word[3:0]                 = update_period_reload;
          rd_word[SCUP_CNT +: 4]       = update_period_counter;
        end
        OFS_IMR2:  rd_word = imr2;
        OFS_ISR2:  rd_word = isr2;
        OFS_ELMR0: rd_word[NUM_CMP-1:0] = event_compare_select[0];
        OFS_ELMR1: rd_word[NUM_CMP-1:0] = event_compare_select[1];
        default: begin
          if (ra[11:7] == CMP_REGION) begin
            case (ra[3:0])
              CMP_SUB_V: begin
                rd_word[15:0]          = cmp_cfg[ra[6:4]].value;
                rd_word[CMPV_CVM]      = cmp_cfg[ra[6:4]].down;
              end
              CMP_SUB_M: begin
                rd_word[0]             = cmp_cfg[ra[6:4]].enable;
                rd_word[COMPARE_MATCH_FLAG_CTR +: 4] = cmp_cfg[ra[6:4]].trig;
                rd_word[COMPARE_MATCH_FLAG_CPR +: 4] = cmp_cfg[ra[6:4]].pmax;
                rd_word[COMPARE_MATCH_FLAG_PCNT +: 4] = compare_period_counter[ra[6:4]];
                rd_word[COMPARE_MATCH_FLAG_COMPARE_UPDATE_PERIOD +: 4] = cmp_cfg[ra[6:4]].uper;
                rd_word[COMPARE_MATCH_FLAG_UCNT +: 4] = compare_update_counter[ra[6:4]];
              end
              default: rd_word = 32'h0;
            endcase
          end else if (ra[11:8] == CH_REGION) begin
            case (ra[4:0])
              CH_SUB_DTY: rd_word[15:0] = chan_cfg[ra[7:5]].duty;
              CH_SUB_PRD: rd_word[15:0] = chan_cfg[ra[7:5]].period;
              CH_SUB_DT: begin
                rd_word[11:0]          = chan_cfg[ra[7:5]].dead_low;
                rd_word[DT_HIGH +: 12] = chan_cfg[ra[7:5]].dead_high;
              end
              default: rd_word = 32'h0;
            endcase
          end
        end
      endcase
    end
  end
  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 12'h000;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= addr_ok & hwrite;
      wr_addr   <= ra;
      hrdata    <= rd_acc ? rd_word : 32'h0;
    end
  end

  // Mode, unlock, update period, flags, events
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chan_enable                     <= '0;
      sync_channel_select             <= '0;
      sync_update_method              <= UPD_MANUAL;
      transfer_request_mode           <= 1'b0;
      transfer_request_compare_select <= 3'h0;
      update_unlock                   <= 1'b0;
      update_period_reload            <= 4'h0;
      update_period_counter           <= 4'h0;
      upr_staged                      <= 4'h0;
      upr_pend                        <= 1'b0;
      isr2                            <= 32'h0;
      imr2                            <= 32'h0;
      irq                             <= 1'b0;
      event_line                      <= '0;
      hit_q                           <= '0;
      dma_todo                        <= '0;
      dma_req                         <= 1'b0;
      event_compare_select[0]         <= '0;
      event_compare_select[1]         <= '0;
    end else begin
      if (we & (wa == OFS_ENA)) chan_enable <= chan_enable | hwdata[NUM_CH-1:0];
      if (we & (wa == OFS_DIS)) chan_enable <= chan_enable & ~hwdata[NUM_CH-1:0];
      if (we & (wa == OFS_SCM)) begin
        sync_channel_select             <= hwdata[NUM_CH-1:0];
        sync_update_method              <= hwdata[SCM_SYNC_UPDATE_METHOD +: 2];
        transfer_request_mode           <= hwdata[SCM_TRANSFER_REQUEST_MODE];
        transfer_request_compare_select <= hwdata[SCM_TRANSFER_REQUEST_COMPARE_SELECT +: 3];
      end
      if (sync_end) update_unlock <= 1'b0;
      if (we & (wa == OFS_SCUC) & hwdata[0]) update_unlock <= 1'b1;
      if (upr_wrap) begin
        update_period_counter <= 4'h0;
        if (upr_pend) update_period_reload <= upr_staged;
        upr_pend <= 1'b0;
      end else if (sync_end) begin
        update_period_counter <= wrap_inc(update_period_counter, update_period_reload);
      end
      if (we & (wa == OFS_SCUP)) update_period_reload <= hwdata[3:0];
      if (we & (wa == OFS_SCUPUPD)) begin
        upr_staged <= hwdata[3:0];
        upr_pend   <= 1'b1;
      end
      if (we & (wa == OFS_IER2)) imr2 <= imr2 | hwdata;
      if (we & (wa == OFS_IDR2)) imr2 <= imr2 & ~hwdata;
      if (we & (wa == OFS_ELMR0)) event_compare_select[0] <= hwdata[NUM_CMP-1:0];
      if (we & (wa == OFS_ELMR1)) event_compare_select[1] <= hwdata[NUM_CMP-1:0];
      isr2 <= next_isr2;
      irq  <= |(next_isr2 & imr2);
      hit_q <= cmp_hit;
      for (int e = 0; e < NUM_EV; e++) begin
        event_line[e] <= |(match_pulse & event_compare_select[e]);
      end
      // Request loads the sync set; each DMA word retires the lowest channel
      if (write_ready_flag_set & dma_mode) begin
        dma_todo <= sync_channel_select;
        dma_req  <= |sync_channel_select;
      end else if (dma_take) begin
        dma_todo[dma_ch] <= 1'b0;
        dma_req  <= |(dma_todo & ~(NUM_CH'(1) << dma_ch));
      end else if (!dma_mode) begin
        dma_todo <= '0;
        dma_req  <= 1'b0;
      end
    end
  end

  // Channel values: direct while disabled, staged while running
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chan_cfg <= '0;
      prd_pend <= '0;
      dty_pend <= '0;
      dt_pend  <= '0;
      for (int c = 0; c < NUM_CH; c++) staged[c] <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (apply_pd[c] & prd_pend[c]) chan_cfg[c].period <= staged[c].period;
        if (apply_pd[c] & dt_pend[c]) begin
          chan_cfg[c].dead_high <= staged[c].dead_high;
          chan_cfg[c].dead_low  <= staged[c].dead_low;
        end
        if (apply_dty[c] & dty_pend[c]) chan_cfg[c].duty <= staged[c].duty;
        if (apply_pd[c])  prd_pend[c] <= 1'b0;
        if (apply_pd[c])  dt_pend[c]  <= 1'b0;
        if (apply_dty[c]) dty_pend[c] <= 1'b0;
      end
      if (we_ch & ~chan_enable[wch]) begin
        case (wa[4:0])
          CH_SUB_DTY: chan_cfg[wch].duty <= hwdata[15:0];
          CH_SUB_PRD: chan_cfg[wch].period <= hwdata[15:0];
          CH_SUB_DT: begin
            chan_cfg[wch].dead_low  <= hwdata[11:0];
            chan_cfg[wch].dead_high <= hwdata[DT_HIGH +: 12];
          end
          default: ;
        endcase
      end
      if (we_ch) begin
        case (wa[4:0])
          CH_SUB_DTYU: begin
            staged[wch].duty <= hwdata[15:0];
            dty_pend[wch]    <= 1'b1;
          end
          CH_SUB_PRDU: begin
            staged[wch].period <= hwdata[15:0];
            prd_pend[wch]      <= 1'b1;
          end
          CH_SUB_DTU: begin
            staged[wch].dead_low  <= hwdata[11:0];
            staged[wch].dead_high <= hwdata[DT_HIGH +: 12];
            dt_pend[wch]          <= 1'b1;
          end
          default: ;
        endcase
      end
      if (dma_take) begin
        staged[dma_ch].duty <= dma_wdata;
        dty_pend[dma_ch]    <= 1'b1;
      end
    end
  end

  // Comparison configuration and counters
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmp_pend <= '0;
      for (int x = 0; x < NUM_CMP; x++) begin
        cmp_cfg[x]                <= '0;
        cmp_staged[x]             <= '0;
        compare_period_counter[x] <= 4'h0;
        compare_update_counter[x] <= 4'h0;
      end
    end else begin
      for (int x = 0; x < NUM_CMP; x++) begin
        if (sync_end) begin
          compare_period_counter[x] <= wrap_inc(compare_period_counter[x], cmp_cfg[x].pmax);
          compare_update_counter[x] <= wrap_inc(compare_update_counter[x], cmp_cfg[x].uper);
        end
        if (cmp_upd[x] & cmp_pend[x]) cmp_cfg[x] <= cmp_staged[x];
        if (cmp_upd[x]) cmp_pend[x] <= 1'b0;
      end
      if (we_cmp) begin
        case (wa[3:0])
          CMP_SUB_V: begin
            cmp_cfg[wcmp].value <= hwdata[15:0];
            cmp_cfg[wcmp].down  <= hwdata[CMPV_CVM];
          end
          CMP_SUB_M: begin
            cmp_cfg[wcmp].enable <= hwdata[0];
            cmp_cfg[wcmp].trig   <= hwdata[COMPARE_MATCH_FLAG_CTR +: 4];
            cmp_cfg[wcmp].pmax   <= hwdata[COMPARE_MATCH_FLAG_CPR +: 4];
            cmp_cfg[wcmp].uper   <= hwdata[COMPARE_MATCH_FLAG_COMPARE_UPDATE_PERIOD +: 4];
          end
          // Value staging alone arms nothing
          CMP_SUB_VU: begin
            cmp_staged[wcmp].value <= hwdata[15:0];
            cmp_staged[wcmp].down  <= hwdata[CMPV_CVM];
          end
          CMP_SUB_MU: begin
            cmp_staged[wcmp].enable <= hwdata[0];
            cmp_staged[wcmp].trig   <= hwdata[COMPARE_MATCH_FLAG_CTR +: 4];
            cmp_staged[wcmp].pmax   <= hwdata[COMPARE_MATCH_FLAG_CPR +: 4];
            cmp_staged[wcmp].uper   <= hwdata[COMPARE_MATCH_FLAG_COMPARE_UPDATE_PERIOD +: 4];
            cmp_pend[wcmp]          <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

endmodule : pwm_compare_sync_update

/* pwm_sync_pkg.sv */
// Purpose: Shared constants and carriers for the sync-update and compare block
// Assumes: AHB-Lite word access, 12-bit register window
// Notes:   Compare counter fields are 4 bits wide, channel-0 counter, channel period and duty 16 bits, dead times 12 bits
package pwm_sync_pkg;

  localparam int NUM_CH  = 8;
  localparam int NUM_CMP = 8;
  localparam int NUM_EV  = 2;

  // Update methods
  localparam logic [1:0] UPD_MANUAL = 2'h0;
  localparam logic [1:0] UPD_AUTO   = 2'h1;
  localparam logic [1:0] UPD_DMA    = 2'h2;

  // Register byte offsets
  localparam logic [11:0] OFS_ENA     = 12'h004;
  localparam logic [11:0] OFS_DIS     = 12'h008;
  localparam logic [11:0] OFS_SR      = 12'h00C;
  localparam logic [11:0] OFS_SCM     = 12'h020;
  localparam logic [11:0] OFS_SCUC    = 12'h028;
  localparam logic [11:0] OFS_SCUP    = 12'h02C;
  localparam logic [11:0] OFS_SCUPUPD = 12'h030;
  localparam logic [11:0] OFS_IER2    = 12'h034;
  localparam logic [11:0] OFS_IDR2    = 12'h038;
  localparam logic [11:0] OFS_IMR2    = 12'h03C;
  localparam logic [11:0] OFS_ISR2    = 12'h040;
  localparam logic [11:0] OFS_ELMR0   = 12'h07C;
  localparam logic [11:0] OFS_ELMR1   = 12'h080;
  // Compare unit x at CMP_BASE + x*16, channel x at CH_BASE + x*32
  localparam logic [4:0]  CMP_REGION  = 5'h02;
  localparam logic [3:0]  CMP_SUB_V   = 4'h0;
  localparam logic [3:0]  CMP_SUB_VU  = 4'h4;
  localparam logic [3:0]  CMP_SUB_M   = 4'h8;
  localparam logic [3:0]  CMP_SUB_MU  = 4'hC;
  localparam logic [3:0]  CH_REGION   = 4'h2;
  localparam logic [4:0]  CH_SUB_DTY  = 5'h00;
  localparam logic [4:0]  CH_SUB_DTYU = 5'h04;
  localparam logic [4:0]  CH_SUB_PRD  = 5'h08;
  localparam logic [4:0]  CH_SUB_PRDU = 5'h0C;
  localparam logic [4:0]  CH_SUB_DT   = 5'h10;
  localparam logic [4:0]  CH_SUB_DTU  = 5'h14;

  // Field positions
  localparam int SCM_SYNC_UPDATE_METHOD  = 16;
  localparam int SCM_TRANSFER_REQUEST_MODE  = 20;
  localparam int SCM_TRANSFER_REQUEST_COMPARE_SELECT = 21;
  localparam int SCUP_CNT  = 4;
  localparam int CMPV_CVM  = 24;
  localparam int COMPARE_MATCH_FLAG_CTR  = 4;
  localparam int COMPARE_MATCH_FLAG_CPR  = 8;
  localparam int COMPARE_MATCH_FLAG_PCNT = 12;
  localparam int COMPARE_MATCH_FLAG_COMPARE_UPDATE_PERIOD = 16;
  localparam int COMPARE_MATCH_FLAG_UCNT = 20;
  localparam int DT_HIGH   = 16;
  localparam int ISR_WRITE_READY_FLAG  = 0;
  localparam int ISR_TRANSFER_END_FLAG = 1;
  localparam int ISR_UNDERRUN_FLAG  = 3;
  localparam int ISR_COMPARE_MATCH_FLAG  = 8;
  localparam int ISR_COMPARE_UPDATE_FLAG  = 16;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] duty;
    logic [11:0] dead_high;
    logic [11:0] dead_low;
  } chan_cfg_t;

  typedef struct packed {
    logic [15:0] counter;
    logic        count_down;
    logic        center_align;
    logic        fault;
  } ch0_status_t;

  typedef struct packed {
    logic [15:0] value;
    logic        down;
    logic        enable;
    logic [3:0]  trig;
    logic [3:0]  pmax;
    logic [3:0]  uper;
  } cmp_cfg_t;

endpackage : pwm_sync_pkg

/* pwm_sync_sva.sv */
// Purpose: Port checks for the sync-update and compare block
// Assumes: hready looped back from hreadyout
// Notes:   Bound onto every instance of the block
`timescale 1ns/1ps
module pwm_sync_sva
  import pwm_sync_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   hsel,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire ch0_status_t            ch0_status,
  input wire logic [NUM_CH-1:0]      chan_period_end,
  input wire logic                   dma_wr,
  input wire logic                   dma_req,
  input wire logic [NUM_EV-1:0]      event_line,
  input wire logic [NUM_CH-1:0]      chan_enable,
  input wire chan_cfg_t [NUM_CH-1:0] chan_cfg
);
  wire take = hsel & htrans[1] & hready;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_fault_held;
    ch0_status.fault [*3];
  endsequence
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_rdata_idle: assert property (!$past(take & ~hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_event_once: assert property ((event_line & $past(event_line)) == 2'h0)
    else $error("event pulse wider than one cycle");
  a_fault_quiet: assert property (s_fault_held |=> event_line == 2'h0)
    else $error("event during channel-0 fault");
  a_cfg_cause: assert property ($changed(chan_cfg) |->
    $past(take & hwrite, 2) || $past(chan_period_end) != 8'h0) else $error("applied value moved unprompted");
  a_enable_cause: assert property ($changed(chan_enable) |-> $past(take & hwrite, 2))
    else $error("enable moved without a write");
  a_req_drop: assert property ($fell(dma_req) |-> $past(dma_wr) || $past(dma_wr, 2))
    else $error("request dropped without a word");
endmodule : pwm_sync_sva

bind pwm_compare_sync_update pwm_sync_sva chk_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .ch0_status(ch0_status), .chan_period_end(chan_period_end), .dma_wr(dma_wr), .dma_req(dma_req),
  .event_line(event_line), .chan_enable(chan_enable), .chan_cfg(chan_cfg));

/* pwm_dma_model.sv */
// Purpose: Behavioural DMA controller feeding duty words
// Assumes: The block picks the channel, words go out in order
// Notes:   stall withholds words on purpose, slow widens the gap
`timescale 1ns/1ps
module pwm_dma_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        dma_req,
  input  wire logic        slow,
  input  wire logic        stall,
  output logic             dma_wr,
  output logic      [15:0] dma_wdata,
  output logic             dma_tx_end
);
  logic [3:0]  gap;
  logic [15:0] word_idx;
  logic        req_q;
  initial {dma_wr, dma_wdata, dma_tx_end} = 18'h0;
  always @(posedge sys_clk) begin
    req_q <= dma_req & ~rst;
    dma_tx_end <= req_q & ~dma_req & ~rst;
    dma_wr <= 1'b0;
    // Released data toggles so a stale word never looks valid
    dma_wdata <= ~dma_wdata;
    if (rst) begin
      gap <= 4'h0;
      word_idx <= 16'hA000;
    end else if (gap != 4'h0) begin
      gap <= gap - 4'h1;
    end else if (dma_req && !stall) begin
      dma_wr <= 1'b1;
      dma_wdata <= word_idx;
      word_idx <= word_idx + 16'h1;
      gap <= slow ? 4'h8 : 4'h3;
    end
  end
endmodule : pwm_dma_model

/* testbench.sv */
// Purpose: Self-checking bench for the sync-update and compare block
// Assumes: Zero-wait register bus, bench drives channel-0 counter
// Notes:   Fixed xorshift seed keeps runs repeatable
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module testbench
  import pwm_sync_pkg::*;
;
  logic sys_clk, rst, hsel, hwrite, stall, slow, c, hreadyout, hresp, dma_wr, dma_tx_end, dma_req, irq;
  logic [31:0] haddr, hwdata, rd, hrdata, seed;
  logic [15:0] v, cv, dma_wdata;
  logic [7:0] cpe, chan_enable;
  logic [1:0] htrans, event_line;
  ch0_status_t cs;
  chan_cfg_t [7:0] chan_cfg;
  int err_count = 0, cmp_count = 0, ev0 = 0, ev1 = 0, e0, e1;
  pwm_compare_sync_update dut_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ch0_status(cs), .chan_period_end(cpe), .dma_wr(dma_wr), .dma_wdata(dma_wdata),
    .dma_tx_end(dma_tx_end), .dma_req(dma_req), .event_line(event_line), .irq(irq),
    .chan_enable(chan_enable), .chan_cfg(chan_cfg));
  pwm_dma_model dma_u (.sys_clk(sys_clk), .rst(rst), .dma_req(dma_req), .slow(slow), .stall(stall),
    .dma_wr(dma_wr), .dma_wdata(dma_wdata), .dma_tx_end(dma_tx_end));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) ev0 += int'(event_line[0] === 1'b1);
  always @(posedge sys_clk) ev1 += int'(event_line[1] === 1'b1);
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : xs
  // Left-aligned counts match on both sweeps, centred on one only
  function automatic int exp_hits(logic center);
    return center ? 1 : 2;
  endfunction : exp_hits
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic pe(logic [7:0] mk);
    cpe <= mk;
    @(posedge sys_clk);
    cpe <= 8'h0;
    tick(2);
  endtask : pe
  task automatic sweep(logic dn, logic flt);
    cs.count_down <= dn;
    cs.fault <= flt;
    for (int i = 0; i < 32; i++) begin
      cs.counter <= dn ? 16'h1F - 16'(i) : 16'(i);
      @(posedge sys_clk);
    end
  endtask : sweep
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  initial begin
    tick(20000);
    err_count++;
    final_report();
  end
  initial begin
    seed = 32'h0000_0042;
    {rst, hsel, hwrite, stall, slow, haddr, hwdata, htrans, cpe, cs} = '0;
    rst = 1'b1;
    tick(12);
    rst <= 1'b0;
    tick(1);
    bus(1'b1, 12'h024, 32'hFFFF_FFFF);
    bus(1'b0, 12'h024, 32'h0);
    `CHK(rd, 32'h0)
    v = xs();
    bus(1'b1, 12'h228, {16'h0, v});
    bus(1'b1, OFS_ENA, 32'h2);
    bus(1'b1, 12'h228, 32'h0000_0123);
    bus(1'b1, 12'h22C, 32'h0000_0777);
    tick(1);
    `CHK(chan_cfg[1].period, v)
    pe(8'h02);
    `CHK(chan_cfg[1].period, 16'h0777)
    $display("test async done");
    bus(1'b1, OFS_SCM, 32'h5);
    bus(1'b1, OFS_ENA, 32'h5);
    bus(1'b1, 12'h24C, 32'h0000_0111);
    v = xs();
    bus(1'b1, 12'h24C, {16'h0, v});
    pe(8'h05);
    `CHK(chan_cfg[2].period, 16'h0)
    `CHK(chan_enable, 8'h07)
    bus(1'b1, OFS_SCUC, 32'h1);
    bus(1'b0, OFS_SCUC, 32'h0);
    `CHK(rd[0], 1'b1)
    pe(8'h01);
    `CHK(chan_cfg[2].period, v)
    bus(1'b0, OFS_SCUC, 32'h0);
    `CHK(rd[0], 1'b0)
    $display("test unlock done");
    bus(1'b1, OFS_SCM, 32'h0002_0005);
    v = xs();
    slow <= v[0];
    pe(8'h01);
    tick(2);
    while (dma_req === 1'b1) @(posedge sys_clk);
    stall <= 1'b1;
    pe(8'h01);
    `CHK(chan_cfg[0].duty, 16'hA000)
    `CHK(chan_cfg[2].duty, 16'hA001)
    `CHK(dma_req, 1'b1)
    pe(8'h01);
    bus(1'b0, OFS_ISR2, 32'h0);
    `CHK(rd[3:0] & 4'hB, 4'hB)
    bus(1'b0, OFS_ISR2, 32'h0);
    `CHK(rd[3:0] & 4'hB, 4'h0)
    $display("test dma done");
    bus(1'b1, OFS_IER2, 32'h100);
    for (int u = 0; u < NUM_CMP; u++) begin
      v = xs();
      c = v[0];
      cv = 16'h1 + 16'(v[15:8] % 8'h1D);
      bus(1'b1, OFS_ELMR0, 32'h1 << u);
      bus(1'b1, OFS_ELMR1, 32'h1 << u);
      bus(1'b1, 12'h100 | (12'(u) << 4), {7'h0, v[1], 8'h0, cv});
      bus(1'b1, 12'h108 | (12'(u) << 4), 32'h1);
      cs.center_align <= c;
      e0 = ev0;
      e1 = ev1;
      sweep(1'b0, 1'b0);
      sweep(1'b1, 1'b0);
      sweep(1'b0, 1'b1);
      tick(3);
      `CHK(ev0 - e0, exp_hits(c))
      `CHK(ev1 - e1, exp_hits(c))
      `CHK(irq, 1'b1)
      bus(1'b0, OFS_ISR2, 32'h0);
      `CHK(rd[8 + u], 1'b1)
      `CHK(irq, 1'b0)
    end
    $display("test compare done");
    bus(1'b1, OFS_SCM, 32'h0012_0005);
    cs.center_align <= 1'b0;
    bus(1'b0, OFS_ISR2, 32'h0);
    sweep(1'b0, 1'b0);
    bus(1'b0, OFS_ISR2, 32'h0);
    `CHK(rd[0], 1'b1)
    bus(1'b1, OFS_SCUPUPD, 32'h1);
    bus(1'b0, OFS_SCUP, 32'h0);
    `CHK(rd[3:0], 4'h0)
    pe(8'h01);
    bus(1'b0, OFS_SCUP, 32'h0);
    `CHK(rd[3:0], 4'h1)
    $display("test period staging done");
    final_report();
  end
endmodule : testbench
